// *** rtl/vec_pkg.sv ***
// constants shared by the interrupt vector, identification and analyser block
// Operation
// - framer0 elastic summary on low bit 2
// - framer0 receive line summary on bit 1
// - framer0 sync summary on bit 0
// - set mask bit forces summary bit low
// - high register holds framers 4-7 summaries
// - high bits 5..0 ordered f5r,f5s,f4h,f4e,f4r,f4s
// - hdlc summary ORs hdlc register, elastic status
// - id holds part number, revision code
// - analyser status set when capture buffer full
// - analyser mask bit suppresses analyser status
// - capture bytes read at 920..93f, first first
// - capture stream from any framer, any stream
// - framers 0-3 in low register, four bits each
// - analyser mask one keeps status at zero
`default_nettype none
package vec_pkg;
  // ***********************************************************
  // register offsets on the processor port
  // ***********************************************************
  localparam logic [11:0] OFF_VEC_MASK_LOW  = 12'h902;
  localparam logic [11:0] OFF_VEC_MASK_HIGH = 12'h903;
  localparam logic [11:0] OFF_ANA_MASK      = 12'h905;
  localparam logic [11:0] OFF_VEC_STAT_LOW  = 12'h910;
  localparam logic [11:0] OFF_VEC_STAT_HIGH = 12'h911;
  localparam logic [11:0] OFF_PART_ID       = 12'h912;
  localparam logic [11:0] OFF_ANA_STAT      = 12'h913;
  localparam logic [11:0] OFF_CAP_FIRST     = 12'h920;
  localparam logic [11:0] OFF_CAP_LAST      = 12'h93f;
  // ***********************************************************
  // field positions and reset values
  // ***********************************************************
  localparam int          SUM_SYNC_POS      = 0;
  localparam int          SUM_RXLINE_POS    = 1;
  localparam int          SUM_ELASTIC_POS   = 2;
  localparam int          SUM_HDLC_POS      = 3;
  localparam int          SUM_PER_FRAMER    = 4;
  localparam int          PART_NUM_LSB      = 3;
  localparam int          ANA_FULL_POS      = 0;
  localparam logic [15:0] VEC_MASK_RESET    = 16'h0000;
  localparam logic        ANA_MASK_RESET    = 1'h0;
  localparam logic [7:0]  CAP_BYTE_RESET    = 8'h00;
  localparam logic [15:0] READ_ZERO         = 16'h0000;
  // part number is an arbitrary neutral value, revision reads as zero
  localparam logic [12:0] PART_NUMBER_DEF   = 13'h0a5a;
  localparam logic [2:0]  REVISION_DEF      = 3'h0;
  // ***********************************************************
  // capture engine states
  // ***********************************************************
  typedef enum logic [2:0] {
    CAP_IDLE = 3'b001,
    CAP_FILL = 3'b010,
    CAP_FULL = 3'b100
  } cap_state_t;
endpackage
`default_nettype wire

// *** rtl/capture_if.sv ***
// signals between the register front end and the capture engine
`default_nettype none
interface capture_if;
  logic       arm;
  logic [2:0] framer_sel;
  logic [1:0] stream_sel;
  logic [4:0] rd_idx;
  logic [7:0] rd_byte;
  logic       full;
  modport ctrl (output arm, framer_sel, stream_sel, rd_idx,
                input rd_byte, full);
  modport eng  (input arm, framer_sel, stream_sel, rd_idx,
                output rd_byte, full);
endinterface
`default_nettype wire

// *** rtl/stream_capture.sv ***
// backplane stream analyser capture engine with its byte buffer
`default_nettype none
module stream_capture #(
  parameter int N_FRAMERS = 8,
  parameter int N_STREAMS = 4,
  parameter int N_BYTES   = 32
) (
  input  wire logic                       clk_sys,
  input  wire logic                       srst,
  input  wire logic [N_FRAMERS*N_STREAMS-1:0] bp_stream,
  input  wire logic                       bp_bit_en,
  capture_if.eng                          cap
);
  vec_pkg::cap_state_t state_ff, nxt_state;
  logic [2:0] bit_cnt_ff, nxt_bit_cnt;
  logic [4:0] byte_cnt_ff, nxt_byte_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] mem [N_BYTES];
  logic       wr_en;
  logic [7:0] wr_byte;
  logic       cur_bit;

  // ***********************************************************
  // stream select and fill sequence
  // ***********************************************************
  // any stream of any framer may feed the shifter
  always_comb begin
    cur_bit = bp_stream[{cap.framer_sel, cap.stream_sel}];
  end

  // bits arrive msb first; the byte is stored on its eighth bit
  always_comb begin
    nxt_state    = state_ff;
    nxt_bit_cnt  = bit_cnt_ff;
    nxt_byte_cnt = byte_cnt_ff;
    nxt_shift    = shift_ff;
    wr_en        = 1'b0;
    wr_byte      = {shift_ff[6:0], cur_bit};
    case (state_ff)
      vec_pkg::CAP_IDLE, vec_pkg::CAP_FULL: begin
        if (cap.arm) begin
          nxt_state    = vec_pkg::CAP_FILL;
          nxt_bit_cnt  = 3'h0;
          nxt_byte_cnt = 5'h00;
        end
      end
      vec_pkg::CAP_FILL: begin
        if (cap.arm) begin
          nxt_bit_cnt  = 3'h0;
          nxt_byte_cnt = 5'h00;
        end else if (bp_bit_en) begin
          nxt_shift   = wr_byte;
          nxt_bit_cnt = bit_cnt_ff + 3'h1;
          if (bit_cnt_ff == 3'h7) begin
            wr_en = 1'b1;
            nxt_byte_cnt = byte_cnt_ff + 5'h01;
            if (byte_cnt_ff == 5'(N_BYTES - 1)) begin
              nxt_state = vec_pkg::CAP_FULL;
            end
          end
        end
      end
      default: begin
        nxt_state = vec_pkg::CAP_IDLE;
      end
    endcase
  end

  // register stage; the buffer clears on reset so reads show zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_ff    <= vec_pkg::CAP_IDLE;
      bit_cnt_ff  <= 3'h0;
      byte_cnt_ff <= 5'h00;
      shift_ff    <= vec_pkg::CAP_BYTE_RESET;
      for (int i = 0; i < N_BYTES; i++) begin
        mem[i] <= vec_pkg::CAP_BYTE_RESET;
      end
    end else begin
      state_ff    <= nxt_state;
      bit_cnt_ff  <= nxt_bit_cnt;
      byte_cnt_ff <= nxt_byte_cnt;
      shift_ff    <= nxt_shift;
      if (wr_en) begin
        mem[byte_cnt_ff] <= wr_byte;
      end
    end
  end

  assign cap.rd_byte = mem[cap.rd_idx];
  assign cap.full    = (state_ff == vec_pkg::CAP_FULL);
endmodule
`default_nettype wire

// *** rtl/framer_irq_vector.sv ***
// global interrupt vector, identification and analyser register block
`default_nettype none
module framer_irq_vector #(
  parameter int          N_FRAMERS   = 8,
  parameter int          N_STREAMS   = 4,
  parameter logic [12:0] PART_NUMBER = vec_pkg::PART_NUMBER_DEF,
  parameter logic [2:0]  REVISION    = vec_pkg::REVISION_DEF
) (
  input  wire logic                           clk_sys,
  input  wire logic                           srst,
  input  wire logic                           cpu_cs,
  input  wire logic                           cpu_rd,
  input  wire logic                           cpu_wr,
  input  wire logic [11:0]                    cpu_addr,
  input  wire logic [15:0]                    cpu_wdata,
  output logic      [15:0]                    cpu_rdata,
  output logic                                cpu_rvalid,
  input  wire logic [N_FRAMERS*16-1:0]        irq_sync_bits,
  input  wire logic [N_FRAMERS*16-1:0]        irq_rxline_bits,
  input  wire logic [N_FRAMERS*16-1:0]        irq_elastic_bits,
  input  wire logic [N_FRAMERS*16-1:0]        elastic_status_bits,
  input  wire logic [N_FRAMERS*16-1:0]        irq_hdlc_bits,
  input  wire logic [N_FRAMERS*N_STREAMS-1:0] bp_stream,
  input  wire logic                           bp_bit_en,
  input  wire logic                           ana_arm,
  input  wire logic [2:0]                     ana_framer_sel,
  input  wire logic [1:0]                     ana_stream_sel
);
  logic [15:0] vec_mask_low_ff, nxt_vec_mask_low;
  logic [15:0] vec_mask_high_ff, nxt_vec_mask_high;
  logic        analyser_status_mask_ff, nxt_analyser_status_mask;
  logic [15:0] rdata_ff, nxt_rdata;
  logic        rvalid_ff, nxt_rvalid;
  logic [N_FRAMERS*4-1:0] raw_sum;
  logic [15:0] vec_stat_low;
  logic [15:0] vec_stat_high;
  logic        ana_stat;
  logic        wr_hit;
  logic        rd_hit;
  logic        cap_hit;

  capture_if cap ();

  // ***********************************************************
  // helpers
  // ***********************************************************
  // a source register is pending while any of its bits is set
  function automatic logic any_set(input logic [15:0] r);
    any_set = |r;
  endfunction

  // ***********************************************************
  // per framer summaries
  // ***********************************************************
  // live OR, no latch: the bit falls once the framer bits are cleared
  always_comb begin
    raw_sum = '0;
    for (int f = 0; f < N_FRAMERS; f++) begin
      raw_sum[f*4 + vec_pkg::SUM_SYNC_POS] =
        any_set(irq_sync_bits[f*16 +: 16]);
      raw_sum[f*4 + vec_pkg::SUM_RXLINE_POS] =
        any_set(irq_rxline_bits[f*16 +: 16]);
      raw_sum[f*4 + vec_pkg::SUM_ELASTIC_POS] =
        any_set(irq_elastic_bits[f*16 +: 16]) |
        any_set(elastic_status_bits[f*16 +: 16]);
      raw_sum[f*4 + vec_pkg::SUM_HDLC_POS] =
        any_set(irq_hdlc_bits[f*16 +: 16]) |
        any_set(elastic_status_bits[f*16 +: 16]);
    end
  end

  // framers 0-3 go low, 4-7 high, each nibble {hdlc,el,rx,sync}
  always_comb begin
    vec_stat_low  = raw_sum[15:0] & ~vec_mask_low_ff;
    vec_stat_high = raw_sum[31:16] & ~vec_mask_high_ff;
  end

  // the mask forces the analyser bit low while set
  always_comb begin
    ana_stat = cap.full & ~analyser_status_mask_ff;
  end

  // ***********************************************************
  // capture engine control
  // ***********************************************************
  assign cap.arm        = ana_arm;
  assign cap.framer_sel = ana_framer_sel;
  assign cap.stream_sel = ana_stream_sel;
  assign cap.rd_idx     = 5'(cpu_addr - vec_pkg::OFF_CAP_FIRST);

  stream_capture #(
    .N_FRAMERS (N_FRAMERS),
    .N_STREAMS (N_STREAMS),
    .N_BYTES   (32)
  ) u_capture (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .bp_stream (bp_stream),
    .bp_bit_en (bp_bit_en),
    .cap       (cap)
  );

  // ***********************************************************
  // processor port
  // ***********************************************************
  // a write and a read in the same cycle are both served
  always_comb begin
    wr_hit  = cpu_cs & cpu_wr;
    rd_hit  = cpu_cs & cpu_rd;
    cap_hit = (cpu_addr >= vec_pkg::OFF_CAP_FIRST) &&
              (cpu_addr <= vec_pkg::OFF_CAP_LAST);
    nxt_vec_mask_low         = vec_mask_low_ff;
    nxt_vec_mask_high        = vec_mask_high_ff;
    nxt_analyser_status_mask = analyser_status_mask_ff;
    if (wr_hit) begin
      case (cpu_addr)
        vec_pkg::OFF_VEC_MASK_LOW:  nxt_vec_mask_low  = cpu_wdata;
        vec_pkg::OFF_VEC_MASK_HIGH: nxt_vec_mask_high = cpu_wdata;
        vec_pkg::OFF_ANA_MASK: begin
          nxt_analyser_status_mask = cpu_wdata[0];
        end
        default: begin
        end
      endcase
    end
  end

  // read data is captured one cycle after the strobe
  always_comb begin
    nxt_rvalid = rd_hit;
    nxt_rdata  = rdata_ff;
    if (rd_hit) begin
      nxt_rdata = vec_pkg::READ_ZERO;
      if (cap_hit) begin
        nxt_rdata[7:0] = cap.rd_byte;
      end else begin
        case (cpu_addr)
          vec_pkg::OFF_VEC_MASK_LOW:  nxt_rdata = vec_mask_low_ff;
          vec_pkg::OFF_VEC_MASK_HIGH: nxt_rdata = vec_mask_high_ff;
          vec_pkg::OFF_ANA_MASK: begin
            nxt_rdata[0] = analyser_status_mask_ff;
          end
          vec_pkg::OFF_VEC_STAT_LOW:  nxt_rdata = vec_stat_low;
          vec_pkg::OFF_VEC_STAT_HIGH: nxt_rdata = vec_stat_high;
          vec_pkg::OFF_PART_ID: begin
            nxt_rdata = {PART_NUMBER, REVISION};
          end
          vec_pkg::OFF_ANA_STAT: begin
            nxt_rdata[vec_pkg::ANA_FULL_POS] = ana_stat;
          end
          default: begin
            nxt_rdata = vec_pkg::READ_ZERO;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      vec_mask_low_ff         <= vec_pkg::VEC_MASK_RESET;
      vec_mask_high_ff        <= vec_pkg::VEC_MASK_RESET;
      analyser_status_mask_ff <= vec_pkg::ANA_MASK_RESET;
      rdata_ff                <= vec_pkg::READ_ZERO;
      rvalid_ff               <= 1'b0;
    end else begin
      vec_mask_low_ff         <= nxt_vec_mask_low;
      vec_mask_high_ff        <= nxt_vec_mask_high;
      analyser_status_mask_ff <= nxt_analyser_status_mask;
      rdata_ff                <= nxt_rdata;
      rvalid_ff               <= nxt_rvalid;
    end
  end

  assign cpu_rdata  = rdata_ff;
  assign cpu_rvalid = rvalid_ff;
endmodule
`default_nettype wire

// *** test/framer_irq_vector_checker.sv ***
// assertion checker for the interrupt vector register block
`default_nettype none
module framer_irq_vector_checker #(
  parameter int          N_FRAMERS   = 8,
  parameter logic [12:0] PART_NUMBER = 13'h0000,
  parameter logic [2:0]  REVISION    = 3'h0
) (
  input wire logic                    clk_sys,
  input wire logic                    srst,
  input wire logic                    cpu_cs,
  input wire logic                    cpu_rd,
  input wire logic [11:0]             cpu_addr,
  input wire logic [15:0]             cpu_rdata,
  input wire logic                    cpu_rvalid,
  input wire logic [N_FRAMERS*16-1:0] irq_sync_bits,
  input wire logic [N_FRAMERS*16-1:0] elastic_status_bits,
  input wire logic [N_FRAMERS*16-1:0] irq_hdlc_bits
);
  logic rd;
  // a read is taken on any rising edge with select and strobe high
  assign rd = cpu_cs & cpu_rd;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  chk_rvalid_pulse: assert property (rd |=> cpu_rvalid)
    else $error("read not answered in the next cycle");
  chk_no_spur_valid: assert property (!rd |=> !cpu_rvalid)
    else $error("read answer without a read");
  chk_rdata_hold: assert property (!cpu_rvalid |-> $stable(cpu_rdata))
    else $error("read data moved without a read");
  chk_id_value: assert property (rd && cpu_addr == 12'h912
    |=> cpu_rdata == {PART_NUMBER, REVISION})
    else $error("identification value wrong");
  chk_cap_upper: assert property (rd && cpu_addr inside {[12'h920:12'h93f]}
    |=> cpu_rdata[15:8] == 8'h00)
    else $error("capture byte upper bits not zero");
  chk_unmapped_zero: assert property (rd && cpu_addr >= 12'h940
    |=> cpu_rdata == 16'h0000)
    else $error("unmapped read not zero");
  // quiet sources must give a low summary whatever the mask holds
  chk_sync_idle: assert property (rd && cpu_addr == 12'h910
    && irq_sync_bits[15:0] == 16'h0000 |=> cpu_rdata[0] == 1'b0)
    else $error("sync summary set with no source");
  chk_hdlc_idle: assert property (rd && cpu_addr == 12'h911
    && irq_hdlc_bits[N_FRAMERS*16-1-:16] == 16'h0000
    && elastic_status_bits[N_FRAMERS*16-1-:16] == 16'h0000
    |=> cpu_rdata[15] == 1'b0)
    else $error("last framer hdlc summary set with no source");
endmodule
bind framer_irq_vector framer_irq_vector_checker #(
  .N_FRAMERS(N_FRAMERS), .PART_NUMBER(PART_NUMBER), .REVISION(REVISION)
) framer_irq_vector_checker_i (
  .clk_sys, .srst, .cpu_cs, .cpu_rd, .cpu_addr, .cpu_rdata, .cpu_rvalid,
  .irq_sync_bits, .elastic_status_bits, .irq_hdlc_bits);
`default_nettype wire

// *** test/framer_irq_vector_tb_top.sv ***
// self-checking bench for the interrupt vector register block
`default_nettype none
module framer_irq_vector_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk_sys = 1'b0, srst = 1'b1, ana_arm = 1'b0, en;
  logic         cpu_cs = 1'b0, cpu_rd = 1'b0, cpu_wr = 1'b0, cpu_rvalid;
  logic         bp_bit_en = 1'b0;
  logic [11:0]  cpu_addr = 12'h000;
  logic [15:0]  cpu_wdata = 16'h0000, cpu_rdata, exp_q [$];
  logic [127:0] src [5];
  logic [31:0]  bp_stream = 32'h00000000, seed = 32'h0000001b, v;
  logic [32:0]  msk = 33'h000000000;
  logic [2:0]   fsel = 3'h0;
  logic [1:0]   ssel = 2'h0;
  logic [7:0]   cap [32];
  logic [11:0]  ra [8] = '{12'h902, 12'h903, 12'h905, 12'h910, 12'h911,
                           12'h913, 12'h920, 12'h940};
  int           num_errors = 0, n_tests = 0, n;
  framer_irq_vector framer_irq_vector_i (
    .clk_sys, .srst, .cpu_cs, .cpu_rd, .cpu_wr, .cpu_addr, .cpu_wdata,
    .cpu_rdata, .cpu_rvalid, .irq_sync_bits(src[0]),
    .irq_rxline_bits(src[1]), .irq_elastic_bits(src[2]),
    .elastic_status_bits(src[3]), .irq_hdlc_bits(src[4]), .bp_stream,
    .bp_bit_en, .ana_arm, .ana_framer_sel(fsel), .ana_stream_sel(ssel));
  always #2.5 clk_sys = ~clk_sys;
  // fixed-seed xorshift, so every run repeats exactly
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic hit(int k, int f);
    return |src[k][f*16+:16];
  endfunction
  // predicted {high, low} vectors from live sources and shadow masks
  function automatic logic [31:0] vec();
    logic [31:0] r;
    for (int f = 0; f < 8; f++)
      r[4*f+:4] = {hit(4, f) | hit(3, f), hit(2, f) | hit(3, f),
                   hit(1, f), hit(0, f)};
    return r & ~msk[31:0];
  endfunction
  // vector reads are predicted at launch, once the sources have settled
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    logic [31:0] p;
    @(posedge clk_sys);
    p = vec();
    {cpu_cs, cpu_rd, cpu_addr} <= {2'b11, a};
    exp_q.push_back(a == 12'h910 ? p[15:0] : a == 12'h911 ? p[31:16] : e);
    @(posedge clk_sys);
    {cpu_cs, cpu_rd} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    {cpu_cs, cpu_wr, cpu_addr, cpu_wdata} <= {2'b11, a, d};
    @(posedge clk_sys);
    {cpu_cs, cpu_wr} <= 2'b00;
    if (a == 12'h902) msk[15:0] = d;
    if (a == 12'h903) msk[31:16] = d;
    if (a == 12'h905) msk[32] = d[0];
  endtask
  // answers come in order, so the oldest note belongs to each answer
  always @(negedge clk_sys) begin
    if (cpu_rvalid === 1'b1) begin
      n_tests++;
      if (exp_q.size() == 0 || cpu_rdata !== exp_q[0]) begin
        num_errors++;
        $display("[ERR] %0t read data %h unexpected", $time, cpu_rdata);
      end
      if (exp_q.size() != 0) exp_q.delete(0);
    end
  end
  task automatic print_verdict();
    // a note still queued means an answer never came back
    if (exp_q.size() != 0) num_errors++;
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // the whole run needs about 1200 cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
  end
  initial begin
    for (int k = 0; k < 5; k++) src[k] = 128'h0;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    foreach (ra[i]) rd(ra[i], 16'h0000);
    // only the mask registers may keep what is written
    foreach (ra[i]) begin
      wr(ra[i], 16'hffff);
      rd(ra[i], i == 2 ? 16'h0001 : i < 2 ? 16'hffff : 16'h0000);
    end
    rd(12'h912, {vec_pkg::PART_NUMBER_DEF, vec_pkg::REVISION_DEF});
    // one source bit at a time, under fresh random masks
    for (int k = 0; k < 5; k++) begin
      for (int f = 0; f < 8; f++) begin
        wr(12'h902, 16'(rnd()));
        wr(12'h903, 16'(rnd()));
        src[k] <= 128'h1 << (f * 16 + (rnd() & 32'hf));
        rd(12'h910, 16'h0000);
        rd(12'h911, 16'h0000);
      end
      src[k] <= 128'h0;
    end
    wr(12'h905, 16'h0000);
    // two captures; other streams carry noise, extra bits hit a full buffer
    repeat (2) begin
      fsel <= 3'(rnd());
      ssel <= 2'(rnd());
      ana_arm <= 1'b1;
      @(posedge clk_sys);
      ana_arm <= 1'b0;
      rd(12'h913, 16'h0000);
      n = 0;
      while (n < 264) begin
        v = rnd();
        en = v[7] | v[3];
        bp_stream <= v;
        bp_bit_en <= en;
        if (en && n < 256) cap[n/8] = {cap[n/8][6:0], v[{fsel, ssel}]};
        n += int'(en);
        @(posedge clk_sys);
      end
      bp_bit_en <= 1'b0;
      rd(12'h913, 16'h0001);
      for (int i = 0; i < 32; i++) rd(12'h920 + 12'(i), {8'h00, cap[i]});
    end
    wr(12'h905, 16'h0001);
    rd(12'h913, 16'h0000);
    wr(12'h905, 16'h0000);
    rd(12'h913, 16'h0001);
    // let the last answer reach the watcher before the verdict
    repeat (2) @(posedge clk_sys);
    print_verdict();
  end
endmodule
`default_nettype wire
